// File: hdl/srw_slave.sv
// Serial register read/write frame slave: header decode, status answer,
// auto-incrementing register writes and reads toward the core clock.
// Assumes the register file answers a read request within a few mclk cycles.
`timescale 1ns/1ps
`default_nettype none

module srw_slave
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic sck_in,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    output var logic miso_out,
    output var logic miso_oe_out,
    input wire srw_pkg::srw_stat_s status_in,
    output var logic wr_en_out,
    output var srw_pkg::srw_wr_s wr_req_out,
    output var logic rd_req_out,
    output var logic [7:0] rd_addr_out,
    input wire logic rd_valid_in,
    input wire logic [15:0] rd_data_in
);
    import srw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Link side, receive (rising serial clock)

    // Frame end clears all per-frame state, so no edge after it is needed
    wire logic link_rst_n;
    assign link_rst_n = reset_n_in & ~ss_n_in;

    logic [15:0] sh_q;
    logic [5:0] pos_q;
    logic [3:0] dbit_q;
    logic [5:0] words_q;
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic wr_tgl_q;
    srw_wr_s wr_hold_q;
    logic rd_tgl_q;
    logic [7:0] rd_hold_q;

    wire logic [15:0] sh_d;
    wire logic hdr_done;
    wire logic cmd_end;
    wire logic adr_end;
    wire logic word_end;
    wire logic word_start;
    wire logic in_range;
    wire logic is_write;
    wire logic is_read;
    wire logic wr_fire;
    wire logic rd_fire;
    wire logic [7:0] start_addr;
    wire logic [7:0] next_addr;
    wire logic [7:0] rd_addr_d;

    assign sh_d = {sh_q[14:0], mosi_in};
    assign hdr_done = (pos_q == SRW_HDR_BITS);
    assign cmd_end = (pos_q == SRW_POS_CMD_END);
    assign adr_end = (pos_q == SRW_POS_ADR_END);
    assign word_end = hdr_done & (dbit_q == SRW_WORD_LAST_BIT);
    assign word_start = hdr_done & (dbit_q == 4'h0);
    assign in_range = (words_q < SRW_MAX_WORDS);
    assign is_write = (cmd_q == SRW_CMD_WRITE);
    assign is_read = (cmd_q == SRW_CMD_READ);
    assign start_addr = sh_d[7:0] & SRW_ADDR_EVEN_MASK;
    assign next_addr = addr_q + SRW_ADDR_STEP;
    assign wr_fire = word_end & in_range & is_write;
    // Prefetch: start word asked for right after the address byte, each
    // next word at the start of the current one; asking at word end
    // would leave only half a serial clock for the answer
    assign rd_fire = is_read & (adr_end
        | (word_start & (words_q < SRW_LAST_WORD)));
    assign rd_addr_d = adr_end ? start_addr : next_addr;

    always_ff @(posedge sck_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            sh_q <= 16'h0000;
            pos_q <= 6'h00;
            dbit_q <= 4'h0;
            words_q <= 6'h00;
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
        end
        else
        begin
            sh_q <= sh_d;
            pos_q <= hdr_done ? pos_q : pos_q + 6'h01;
            dbit_q <= hdr_done ? dbit_q + 4'h1 : 4'h0;
            words_q <= (word_end & in_range) ? words_q + 6'h01 : words_q;
            cmd_q <= cmd_end ? sh_d[7:0] : cmd_q;
            addr_q <= adr_end ? start_addr
                : ((word_end & in_range) ? next_addr : addr_q);
        end
    end

    // Toggles survive frame end; clearing them per frame would fake events
    always_ff @(posedge sck_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_tgl_q <= 1'b0;
            wr_hold_q <= '0;
            rd_tgl_q <= 1'b0;
            rd_hold_q <= 8'h00;
        end
        else
        begin
            wr_tgl_q <= wr_tgl_q ^ wr_fire;
            wr_hold_q <= wr_fire ? {addr_q, sh_d} : wr_hold_q;
            rd_tgl_q <= rd_tgl_q ^ rd_fire;
            rd_hold_q <= rd_fire ? rd_addr_d : rd_hold_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side, transmit (falling serial clock)

    logic [31:0] tx_q;
    logic miso_q;
    srw_stat_s stat_snap_q;
    logic [15:0] rd_word_q;

    wire logic load_stat;
    wire logic load_word;
    wire logic [31:0] tx_d;

    assign load_stat = (pos_q == 6'h00);
    assign load_word = hdr_done & (dbit_q == 4'h0) & is_read & in_range;
    // Write data field shifts zeros; content there is don't-care
    assign tx_d = load_stat ? stat_snap_q
        : (load_word ? {rd_word_q, SRW_WORD_ZERO}
        : {tx_q[30:0], 1'b0});

    always_ff @(negedge sck_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            tx_q <= 32'h0000_0000;
            miso_q <= 1'b0;
        end
        else
        begin
            tx_q <= tx_d;
            miso_q <= tx_d[31];
        end
    end

    assign miso_out = miso_q;

    ////////////////////////////////////////////////////////////////////////
    // Core side: synchronisers and request pulses

    logic ss_meta_q;
    logic ss_sync_q;
    logic [2:0] wr_sy_q;
    logic [2:0] rd_sy_q;
    logic oe_q;
    logic wr_en_q;
    srw_wr_s wr_out_q;
    logic rd_req_q;
    logic [7:0] rd_addr_q;

    wire logic wr_edge;
    wire logic rd_edge;

    assign wr_edge = wr_sy_q[1] ^ wr_sy_q[2];
    assign rd_edge = rd_sy_q[1] ^ rd_sy_q[2];

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ss_meta_q <= 1'b1;
            ss_sync_q <= 1'b1;
            wr_sy_q <= 3'h0;
            rd_sy_q <= 3'h0;
            oe_q <= 1'b0;
        end
        else
        begin
            ss_meta_q <= ss_n_in;
            ss_sync_q <= ss_meta_q;
            wr_sy_q <= {wr_sy_q[1:0], wr_tgl_q};
            rd_sy_q <= {rd_sy_q[1:0], rd_tgl_q};
            oe_q <= ~ss_sync_q;
        end
    end

    // Hold registers on the link side stay put for a whole word,
    // so sampling them after the toggle edge is safe
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_en_q <= 1'b0;
            wr_out_q <= '0;
            rd_req_q <= 1'b0;
            rd_addr_q <= 8'h00;
        end
        else
        begin
            wr_en_q <= wr_edge;
            wr_out_q <= wr_edge ? wr_hold_q : wr_out_q;
            rd_req_q <= rd_edge;
            rd_addr_q <= rd_edge ? rd_hold_q : rd_addr_q;
        end
    end

    // Status frozen while a frame runs; limitation: freeze lags select by
    // up to two mclk cycles, inside the select lead time
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stat_snap_q <= '0;
            rd_word_q <= 16'h0000;
        end
        else
        begin
            stat_snap_q <= ss_sync_q ? status_in : stat_snap_q;
            rd_word_q <= rd_valid_in ? rd_data_in : rd_word_q;
        end
    end

    assign miso_oe_out = oe_q;
    assign wr_en_out = wr_en_q;
    assign wr_req_out = wr_out_q;
    assign rd_req_out = rd_req_q;
    assign rd_addr_out = rd_addr_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic wr_seen_q;
    logic [7:0] wr_last_q;
    logic rd_seen_q;
    logic [7:0] rd_last_q;

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_seen_q <= 1'b0;
            wr_last_q <= 8'h00;
            rd_seen_q <= 1'b0;
            rd_last_q <= 8'h00;
        end
        else
        begin
            wr_seen_q <= wr_en_q | (wr_seen_q & ~ss_sync_q);
            wr_last_q <= wr_en_q ? wr_out_q.addr : wr_last_q;
            rd_seen_q <= rd_req_q | (rd_seen_q & ~ss_sync_q);
            rd_last_q <= rd_req_q ? rd_addr_q : rd_last_q;
        end
    end

    AST_OE_FOLLOWS_SELECT: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        $fell(ss_sync_q) |=> miso_oe_out ##1 (miso_oe_out || ss_sync_q))
        else $error("output enable did not follow select");
    AST_OE_RELEASE: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        ss_sync_q [*2] |-> !miso_oe_out)
        else $error("output driven while deselected");
    AST_WR_ADDR_EVEN: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        wr_en_out |-> (wr_req_out.addr[0] == 1'b0))
        else $error("odd write address");
    AST_RD_ADDR_EVEN: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        rd_req_out |-> (rd_addr_out[0] == 1'b0))
        else $error("odd read address");
    AST_WR_STEP: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (wr_en_out && wr_seen_q && !ss_sync_q)
        |-> (wr_req_out.addr == wr_last_q + SRW_ADDR_STEP))
        else $error("write address did not advance by two");
    AST_RD_STEP: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (rd_req_out && rd_seen_q && !ss_sync_q)
        |-> (rd_addr_out == rd_last_q + SRW_ADDR_STEP))
        else $error("read address did not advance by two");
    AST_WR_PULSE: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        wr_en_out |=> !wr_en_out)
        else $error("write strobe longer than one cycle");
    AST_STATUS_FROZEN: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (!ss_sync_q && !$past(ss_sync_q)) |-> $stable(stat_snap_q))
        else $error("status snapshot changed inside a frame");
    AST_WR_ONLY_ON_WRITE: assert property (
        @(posedge sck_in) disable iff (!link_rst_n)
        wr_fire |-> (cmd_q == SRW_CMD_WRITE) && hdr_done)
        else $error("write issued outside a write data field");
    AST_RD_ONLY_ON_READ: assert property (
        @(posedge sck_in) disable iff (!link_rst_n)
        rd_fire |-> (cmd_q == SRW_CMD_READ))
        else $error("read issued outside a read frame");
    AST_WORD_LIMIT: assert property (
        @(posedge sck_in) disable iff (!link_rst_n)
        !in_range |-> !wr_fire && !rd_fire)
        else $error("transfer beyond the word limit");

    COV_WRITE: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in) wr_en_out);
    COV_MULTI_WRITE: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        wr_en_out && wr_seen_q && !ss_sync_q);
    COV_READ: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in) rd_req_out);
    COV_MULTI_READ: cover property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        rd_req_out && rd_seen_q && !ss_sync_q);

endmodule : srw_slave

`default_nettype wire

// File: hdl/srw_pkg.sv
// Constants and carrier types for the serial register read/write slave.
// Assumes a single serial master that keeps to the frame layout below.
//
// Contract
// - First byte is the command; 02h selects a register write frame.
// - Second header byte is the start register address of the transfer.
// - An odd start address is forced even by clearing its lowest bit.
// - Header answer is two 16-bit status words, bytes 0-1 then 2-3.
// - Command 03h is a read frame; data field returns register contents.
// - Reads reach settings and monitoring locations chosen by the address.
// - First data word shifted out in a read is the start address word.
// - After each read word the address advances by two for the next.
// - Mode 3: sample input on rising clock, shift output on falling.
// - Multi-byte fields are big-endian, most significant bit first.
package srw_pkg;

    localparam logic [7:0] SRW_CMD_WRITE = 8'h02;
    localparam logic [7:0] SRW_CMD_READ = 8'h03;
    localparam logic [7:0] SRW_ADDR_EVEN_MASK = 8'hFE;
    localparam logic [7:0] SRW_ADDR_STEP = 8'h02;
    localparam logic [5:0] SRW_POS_CMD_END = 6'h07;
    localparam logic [5:0] SRW_POS_ADR_END = 6'h0F;
    localparam logic [5:0] SRW_HDR_BITS = 6'h20;
    localparam logic [3:0] SRW_WORD_LAST_BIT = 4'hF;
    localparam logic [5:0] SRW_MAX_WORDS = 6'h20;
    localparam logic [5:0] SRW_LAST_WORD = 6'h1F;
    localparam logic [15:0] SRW_WORD_ZERO = 16'h0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } srw_wr_s;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
    } srw_stat_s;

endpackage : srw_pkg

// File: testbench/srw_master.sv
// Serial master model: mode 3 frames, words sent and taken MSB first.
// Assumes the bench loads txw before run and reads rxw after it.
`timescale 1ns/1ps
`default_nettype none

module srw_master
(
    output var logic sck_out,
    output var logic ss_n_out,
    output var logic mosi_out,
    input wire logic miso_in
);
    logic [15:0] txw [0:35];
    logic [15:0] rxw [0:35];
    initial
    begin
        sck_out = 1'b1;
        ss_n_out = 1'b0 | 1'b1;
        mosi_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Clock stands high outside frames; no gaps inside a frame
    task automatic run(input int nbits);
        int i;
        ss_n_out = 1'b0;
        #128;
        for (i = 0; i < nbits; i++)
        begin
            sck_out = 1'b0;
            mosi_out = txw[i / 16][15 - i % 16];
            #32;
            sck_out = 1'b1;
            rxw[i / 16][15 - i % 16] = miso_in;
            #32;
        end
        #64;
        ss_n_out = 1'b1;
        // Released line must not keep the last bit
        mosi_out = ~mosi_out;
    endtask : run
endmodule : srw_master
`default_nettype wire

// File: testbench/srw_slave_tb_top.sv
// Bench for the serial register slave: master model plus register side.
// Assumes the register side answers each read one mclk after the request.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end

module srw_slave_tb_top;
    import srw_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic sck, ss_n, mosi, miso, miso_oe, wr_en, rd_req;
    logic rd_valid = 1'b0;
    logic [15:0] rd_data = 16'h0000;
    logic [7:0] rd_addr;
    srw_stat_s status = '0;
    srw_wr_s wr_req;
    logic [7:0] rdq [$];
    srw_wr_s wrq [$];
    int fail_count = 0;
    int checked = 0;
    wire logic miso_w;
    // No pull on the line: released level is the inverse
    assign miso_w = miso_oe ? miso : ~miso;
    initial
    begin
        forever #12.5 mclk_in = ~mclk_in;
    end
    srw_master m (.sck_out(sck), .ss_n_out(ss_n), .mosi_out(mosi),
        .miso_in(miso_w));
    srw_slave dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .sck_in(sck), .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .status_in(status), .wr_en_out(wr_en),
        .wr_req_out(wr_req), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
        .rd_valid_in(rd_valid), .rd_data_in(rd_data));
    ////////////////////////////////////////////////////////////////////////
    // Register side: read word is a tag byte plus its address
    always @(posedge mclk_in)
    begin
        rd_valid <= rd_req;
        if (rd_req === 1'b1)
        begin
            rd_data <= {8'hA5, rd_addr};
            rdq.push_back(rd_addr);
        end
        if (wr_en === 1'b1)
            wrq.push_back(wr_req);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic [15:0] h0, input srw_stat_s st,
        input int nbits);
        int i;
        @(posedge mclk_in);
        status <= st;
        rdq.delete();
        wrq.delete();
        m.txw[0] = h0;
        m.txw[1] = SRW_WORD_ZERO;
        for (i = 2; i < 36; i++)
            m.txw[i] = SRW_WORD_ZERO;
        for (i = 2; i < 36 && h0[15:8] == SRW_CMD_WRITE; i++)
            m.txw[i] = 16'(16'h1000 + i);
        @(posedge mclk_in);
        fork
            m.run(nbits);
            begin
                #1010;
                `CHK("oe", 1'b1, miso_oe)
            end
        join
        repeat (8) @(posedge mclk_in);
        `CHK("stat0", st.first, m.rxw[0])
        `CHK("stat1", st.second, m.rxw[1])
    endtask : frame
    // Frames must stand at least 1 ms apart
    task automatic frame_gap;
        repeat (40000) @(posedge mclk_in);
    endtask : frame_gap
    ////////////////////////////////////////////////////////////////////////
    // 33 words plus a stray byte: only 32 whole words land
    task automatic write_burst;
        int i;
        srw_wr_s w;
        frame({SRW_CMD_WRITE, 8'h05}, '{16'h1234, 16'h5678}, 16 * 35 + 8);
        `CHK("wr_n", 32, wrq.size())
        for (i = 0; i < 32 && wrq.size() > 0; i++)
        begin
            w = wrq.pop_front();
            `CHK("wr_a", 8'(8'h04 + 2 * i), w.addr)
            `CHK("wr_d", 16'(16'h1002 + i), w.data)
        end
    endtask : write_burst
    task automatic read_burst;
        int i;
        frame({SRW_CMD_READ, 8'h03}, '{16'hC3A0, 16'h0F5A}, 16 * 5);
        `CHK("rd_n", 1'b1, rdq.size() >= 3)
        for (i = 0; i < 3 && rdq.size() > i; i++)
        begin
            `CHK("rd_a", 8'(8'h02 + 2 * i), rdq[i])
            `CHK("rd_w", {8'hA5, 8'(8'h02 + 2 * i)}, m.rxw[i + 2])
        end
    endtask : read_burst
    // Other command: status only, no requests
    task automatic other_cmd;
        frame(16'h0800, '{16'h8001, 16'h7FFE}, 16 * 3);
        `CHK("req_n", 0, wrq.size() + rdq.size())
        `CHK("oe_off", 1'b0, miso_oe)
    endtask : other_cmd
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    initial
    begin
        #2500000;
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        write_burst();
        frame_gap();
        read_burst();
        frame_gap();
        other_cmd();
        summarize();
    end
endmodule : srw_slave_tb_top
`default_nettype wire
